// *** src/adc_cfg_pkg.sv ***
/*
 * adc_cfg_pkg: register offsets, field positions, reset values and carrier
 * types for the converter mode and output configuration bank.
 * Assumes a 16-bit register word and an 8-bit register address from the
 * serial control front end.
 */
package adc_cfg_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;

	// register offsets
	localparam logic [7:0] OFS_SOFT_RESET   = 8'h00;
	localparam logic [7:0] OFS_MODE_DIVIDER = 8'h31;
	localparam logic [7:0] OFS_ROUTE_UPPER  = 8'h3b;
	localparam logic [7:0] OFS_LANE_PHASE   = 8'h42;
	localparam logic [7:0] OFS_TEST_PATTERN = 8'h45;
	localparam logic [7:0] OFS_DATA_FORMAT  = 8'h46;
	localparam logic [7:0] OFS_CORE_CURRENT = 8'h50;
	localparam logic [7:0] OFS_SERIAL_MODE  = 8'h52;
	localparam logic [7:0] OFS_TIMING_SHIFT = 8'h53;
	localparam logic [7:0] OFS_FS_TRIM      = 8'h55;
	localparam logic [7:0] OFS_WAKE_TIME    = 8'h56;

	// field positions (lsb) within their registers
	localparam int POS_RESET      = 0;
	localparam int POS_INTERLEAVE = 0;
	localparam int POS_PRECISION  = 3;
	localparam int POS_DIVIDE     = 8;
	localparam int POS_ROUTE3     = 0;
	localparam int POS_ROUTE4     = 8;
	localparam int POS_PHASE      = 5;
	localparam int POS_DESKEW     = 0;
	localparam int POS_SYNC       = 1;
	localparam int POS_TWOS       = 2;
	localparam int POS_MSB_FIRST  = 3;
	localparam int POS_CURRENT    = 0;
	localparam int POS_VCM        = 4;
	localparam int POS_PD_KIND    = 0;
	localparam int POS_WORD_WIDTH = 0;
	localparam int POS_LOW_CLK    = 3;
	localparam int POS_ADVANCE    = 4;
	localparam int POS_DELAY      = 5;
	localparam int POS_TRIM       = 0;
	localparam int POS_STARTUP    = 0;

	// reset values
	localparam logic [1:0] RST_PHASE      = 2'h2;   // code for the 90 degree relation
	localparam logic [2:0] RST_WORD_WIDTH = 3'h0;   // code for 12-bit words
	localparam logic [2:0] RST_INTERLEAVE = 3'h4;   // quad channel high speed
	localparam logic [1:0] RST_DIVIDE     = 2'h0;   // divide by 1
	localparam logic [4:0] RST_ROUTE3     = 5'h08;  // input 3
	localparam logic [4:0] RST_ROUTE4     = 5'h10;  // input 4
	localparam logic [5:0] RST_TRIM       = 6'h20;  // no change of full scale
	localparam logic [2:0] RST_CURRENT    = 3'h0;
	localparam logic [1:0] RST_VCM        = 2'h0;
	localparam logic [2:0] RST_STARTUP    = 3'h0;

	// interleave field codes
	localparam logic [2:0] IL_SINGLE = 3'h1;
	localparam logic [2:0] IL_DUAL   = 3'h2;
	localparam logic [2:0] IL_QUAD   = 3'h4;

	// branches interleaved per channel
	localparam logic [3:0] BR_SINGLE = 4'h8;
	localparam logic [3:0] BR_DUAL   = 4'h4;
	localparam logic [3:0] BR_QUAD   = 4'h2;
	localparam logic [3:0] BR_PREC   = 4'h1;

	// channel index of converters 4..1, two bits each
	localparam logic [7:0] MAP_SINGLE = 8'h00;
	localparam logic [7:0] MAP_DUAL   = 8'h50;
	localparam logic [7:0] MAP_QUAD   = 8'he4;

	typedef enum logic [2:0] {
		MODE_SINGLE    = 3'h0,
		MODE_DUAL      = 3'h1,
		MODE_QUAD      = 3'h3,
		MODE_PRECISION = 3'h2,
		MODE_ILLEGAL   = 3'h6
	} mode_t;

	// fields that wait for a power-down cycle
	typedef struct packed {
		logic [2:0] word_width;
		logic       low_clk;
		logic [2:0] startup;
		logic       precision;
		logic [2:0] interleave;
		logic [1:0] divide;
	} pd_cfg_t;

	typedef struct packed {
		logic [1:0] phase;
		logic       deskew;
		logic       sync_pat;
		logic       twos;
		logic       msb_first;
		logic       pd_kind;
		logic [4:0] route3;
		logic [4:0] route4;
		logic       advance;
		logic       delay;
		logic [5:0] trim;
		logic [2:0] current;
		logic [1:0] vcm;
		pd_cfg_t    pend;
	} cfg_t;

	localparam pd_cfg_t PD_CFG_RESET = '{
		word_width: RST_WORD_WIDTH, low_clk: 1'b0, startup: RST_STARTUP,
		precision: 1'b0, interleave: RST_INTERLEAVE, divide: RST_DIVIDE};

	localparam cfg_t CFG_RESET = '{
		phase: RST_PHASE, deskew: 1'b0, sync_pat: 1'b0, twos: 1'b0,
		msb_first: 1'b0, pd_kind: 1'b0, route3: RST_ROUTE3, route4: RST_ROUTE4,
		advance: 1'b0, delay: 1'b0, trim: RST_TRIM, current: RST_CURRENT,
		vcm: RST_VCM, pend: PD_CFG_RESET};

endpackage : adc_cfg_pkg

// *** src/sample_divider.sv ***
/*
 * sample_divider: turns the input clock into a one-cycle sampling enable at
 * clock/1, /2, /4 or /8.
 * Assumes the factor code comes from flip-flops on the same clock.
 */
`timescale 1ns/1ps
module sample_divider
	import adc_cfg_pkg::*;
#(
	parameter int CNT_W = 3
) (
	input  wire logic       clock_i,  // input clock
	input  wire logic       reset_i,  // synchronous, active high
	input  wire logic [1:0] code_i,   // divider factor code
	output logic            tick_o    // sampling enable pulse
);

	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] next_count;
	logic [CNT_W-1:0] limit;

	always_comb begin
		limit = CNT_W'((1 << code_i) - 1);
		// >= so a smaller factor never has to wrap the counter first
		tick_o = (count >= limit);
		next_count = tick_o ? '0 : CNT_W'(count + 1'b1);
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

endmodule : sample_divider

// *** src/adc_mode_and_output_config.sv ***
/*
 * adc_mode_and_output_config: register bank for operating mode, sampling
 * clock divider, input routing and serial output controls.
 * Assumes the serial control front end delivers one write strobe per
 * completed command and a read address; the power-down pin is asynchronous.
 */
// Operation
// - two-bit lane clock phase, resets to 90 degrees
// - deskew and sync pattern bits, reset inactive
// - format bit set gives two's complement
// - order bit set sends msb first
// - power-down output kind, reset high impedance
// - three-bit word width, 12-bit default, needs power-down
// - advance bit moves lanes one cycle earlier
// - delay bit moves lanes one cycle later
// - six-bit full-scale trim, reset means no change
// - writes accepted while powered down
// - marked fields apply only after power-down cycle
// - reset bit restores all defaults, self-clears
// - precision bit plus interleave field select mode
// - dual pairs converters, quad maps one each
// - quad two, dual four, single eight branches
// - precision mode uses one branch each
// - divider gives clock over 1, 2, 4, 8
// - divider codes 00..11 mean 1..8
// - routing change applies at command end
`timescale 1ns/1ps
module adc_mode_and_output_config
	import adc_cfg_pkg::*;
(
	input  wire logic              clock_i,        // 20 MHz clock
	input  wire logic              reset_i,        // synchronous, active high
	input  wire logic              wr_en_i,        // write strobe, one per command
	input  wire logic [ADDR_W-1:0] wr_addr_i,      // write register offset
	input  wire logic [DATA_W-1:0] wr_data_i,      // write data
	input  wire logic [ADDR_W-1:0] rd_addr_i,      // read register offset
	output logic      [DATA_W-1:0] rd_data_o,      // read data, one cycle later
	input  wire logic              powerdown_i,    // power-down pin, asynchronous
	output cfg_t                   cfg_o,          // written settings
	output pd_cfg_t                active_o,       // power-down fields in force
	output mode_t                  mode_o,         // decoded operating mode
	output logic      [3:0]        branches_o,     // branches per channel
	output logic      [7:0]        conv_channel_o, // channel of converters 4..1
	output logic                   sample_en_o     // sampling clock enable
);

	typedef struct packed {
		cfg_t              cfg;
		pd_cfg_t           act;
		logic              pd_meta;
		logic              pd_sync;
		logic [DATA_W-1:0] rd_data;
		mode_t             mode;
		logic [3:0]        branches;
		logic [7:0]        conv_map;
	} state_t;

	localparam state_t STATE_RESET = '{
		cfg: CFG_RESET, act: PD_CFG_RESET, pd_meta: 1'b0, pd_sync: 1'b0,
		rd_data: '0, mode: MODE_QUAD, branches: BR_QUAD, conv_map: MAP_QUAD};

	state_t st;
	state_t next_st;
	logic   soft_reset;

	function automatic mode_t decode_mode(input pd_cfg_t p);
		mode_t m;
		m = MODE_ILLEGAL;
		if (p.precision && p.interleave == '0) begin
			m = MODE_PRECISION;
		end else if (!p.precision) begin
			unique case (p.interleave)
				IL_SINGLE: m = MODE_SINGLE;
				IL_DUAL:   m = MODE_DUAL;
				IL_QUAD:   m = MODE_QUAD;
				default:   m = MODE_ILLEGAL;
			endcase
		end
		return m;
	endfunction : decode_mode

	function automatic logic [DATA_W-1:0] read_back(input cfg_t c, input logic [ADDR_W-1:0] a);
		logic [DATA_W-1:0] d;
		d = '0;
		unique case (a)
			OFS_MODE_DIVIDER: begin
				d[POS_INTERLEAVE +: 3] = c.pend.interleave;
				d[POS_PRECISION] = c.pend.precision;
				d[POS_DIVIDE +: 2] = c.pend.divide;
			end
			OFS_ROUTE_UPPER: begin
				d[POS_ROUTE3 +: 5] = c.route3;
				d[POS_ROUTE4 +: 5] = c.route4;
			end
			OFS_LANE_PHASE:   d[POS_PHASE +: 2] = c.phase;
			OFS_TEST_PATTERN: begin
				d[POS_DESKEW] = c.deskew;
				d[POS_SYNC] = c.sync_pat;
			end
			OFS_DATA_FORMAT: begin
				d[POS_TWOS] = c.twos;
				d[POS_MSB_FIRST] = c.msb_first;
			end
			OFS_CORE_CURRENT: begin
				d[POS_CURRENT +: 3] = c.current;
				d[POS_VCM +: 2] = c.vcm;
			end
			OFS_SERIAL_MODE:  d[POS_PD_KIND] = c.pd_kind;
			OFS_TIMING_SHIFT: begin
				d[POS_WORD_WIDTH +: 3] = c.pend.word_width;
				d[POS_LOW_CLK] = c.pend.low_clk;
				d[POS_ADVANCE] = c.advance;
				d[POS_DELAY] = c.delay;
			end
			OFS_FS_TRIM:   d[POS_TRIM +: 6] = c.trim;
			OFS_WAKE_TIME: d[POS_STARTUP +: 3] = c.pend.startup;
			// the reset bit and unmapped offsets read zero
			default: d = '0;
		endcase
		return d;
	endfunction : read_back

	assign soft_reset = wr_en_i && wr_addr_i == OFS_SOFT_RESET && wr_data_i[POS_RESET];

	always_comb begin
		next_st = st;
		next_st.pd_meta = powerdown_i;
		next_st.pd_sync = st.pd_meta;
		// writes are taken whether or not the device is powered down
		if (wr_en_i) begin
			unique case (wr_addr_i)
				OFS_MODE_DIVIDER: begin
					next_st.cfg.pend.interleave = wr_data_i[POS_INTERLEAVE +: 3];
					next_st.cfg.pend.precision = wr_data_i[POS_PRECISION];
					next_st.cfg.pend.divide = wr_data_i[POS_DIVIDE +: 2];
				end
				OFS_ROUTE_UPPER: begin
					next_st.cfg.route3 = wr_data_i[POS_ROUTE3 +: 5];
					next_st.cfg.route4 = wr_data_i[POS_ROUTE4 +: 5];
				end
				OFS_LANE_PHASE:   next_st.cfg.phase = wr_data_i[POS_PHASE +: 2];
				OFS_TEST_PATTERN: begin
					next_st.cfg.deskew = wr_data_i[POS_DESKEW];
					next_st.cfg.sync_pat = wr_data_i[POS_SYNC];
				end
				OFS_DATA_FORMAT: begin
					next_st.cfg.twos = wr_data_i[POS_TWOS];
					next_st.cfg.msb_first = wr_data_i[POS_MSB_FIRST];
				end
				OFS_CORE_CURRENT: begin
					next_st.cfg.current = wr_data_i[POS_CURRENT +: 3];
					next_st.cfg.vcm = wr_data_i[POS_VCM +: 2];
				end
				OFS_SERIAL_MODE:  next_st.cfg.pd_kind = wr_data_i[POS_PD_KIND];
				OFS_TIMING_SHIFT: begin
					next_st.cfg.pend.word_width = wr_data_i[POS_WORD_WIDTH +: 3];
					next_st.cfg.pend.low_clk = wr_data_i[POS_LOW_CLK];
					next_st.cfg.advance = wr_data_i[POS_ADVANCE];
					next_st.cfg.delay = wr_data_i[POS_DELAY];
				end
				OFS_FS_TRIM:   next_st.cfg.trim = wr_data_i[POS_TRIM +: 6];
				OFS_WAKE_TIME: next_st.cfg.pend.startup = wr_data_i[POS_STARTUP +: 3];
				// undefined offsets are ignored; the host must not use them
				default: next_st.cfg = st.cfg;
			endcase
		end
		// held fields follow the written ones only while powered down
		if (st.pd_sync) begin
			next_st.act = st.cfg.pend;
		end
		if (soft_reset) begin
			next_st.cfg = CFG_RESET;
			next_st.act = PD_CFG_RESET;
		end
		next_st.rd_data = read_back(st.cfg, rd_addr_i);
		next_st.mode = decode_mode(next_st.act);
		unique case (next_st.mode)
			MODE_SINGLE: begin
				next_st.branches = BR_SINGLE;
				next_st.conv_map = MAP_SINGLE;
			end
			MODE_DUAL: begin
				next_st.branches = BR_DUAL;
				next_st.conv_map = MAP_DUAL;
			end
			MODE_PRECISION: begin
				next_st.branches = BR_PREC;
				next_st.conv_map = MAP_QUAD;
			end
			// quad, and illegal codes fall back to quad routing
			default: begin
				next_st.branches = BR_QUAD;
				next_st.conv_map = MAP_QUAD;
			end
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			st <= STATE_RESET;
		end else begin
			st <= next_st;
		end
	end

	sample_divider #(
		.CNT_W (3)
	) u_divider (
		.clock_i (clock_i),
		.reset_i (reset_i),
		.code_i  (st.act.divide),
		.tick_o  (sample_en_o)
	);

	assign rd_data_o = st.rd_data;
	assign cfg_o = st.cfg;
	assign active_o = st.act;
	assign mode_o = st.mode;
	assign branches_o = st.branches;
	assign conv_channel_o = st.conv_map;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (reset_i);

	sequence route_write;
		wr_en_i && wr_addr_i == OFS_ROUTE_UPPER && !soft_reset;
	endsequence

	// a held-field copy two edges back, with no soft reset in between
	sequence pd_window;
		st.pd_sync && !soft_reset ##1 !soft_reset;
	endsequence

	// a divide-by-two tick, and in that cycle and the next the factor cannot move
	sequence half_tick;
		sample_en_o && active_o.divide == 2'h1;
	endsequence

	sequence quiet_two;
		(!soft_reset && !st.pd_sync) [*2];
	endsequence

	soft_reset_all_a: assert property (
		soft_reset |=> cfg_o == CFG_RESET && active_o == PD_CFG_RESET)
		else $error("soft reset did not restore defaults");
	reset_reads_zero_a: assert property (
		rd_addr_i == OFS_SOFT_RESET |=> rd_data_o == '0)
		else $error("reset register read nonzero");
	phase_write_a: assert property (
		wr_en_i && wr_addr_i == OFS_LANE_PHASE |=>
			cfg_o.phase == $past(wr_data_i[POS_PHASE +: 2]))
		else $error("lane phase not written");
	pattern_write_a: assert property (
		wr_en_i && wr_addr_i == OFS_TEST_PATTERN |=>
			cfg_o.deskew == $past(wr_data_i[POS_DESKEW]) &&
			cfg_o.sync_pat == $past(wr_data_i[POS_SYNC]))
		else $error("test pattern bits not written");
	format_write_a: assert property (
		wr_en_i && wr_addr_i == OFS_DATA_FORMAT |=>
			cfg_o.twos == $past(wr_data_i[POS_TWOS]) &&
			cfg_o.msb_first == $past(wr_data_i[POS_MSB_FIRST]))
		else $error("format bits not written");
	pd_kind_write_a: assert property (
		wr_en_i && wr_addr_i == OFS_SERIAL_MODE |=>
			cfg_o.pd_kind == $past(wr_data_i[POS_PD_KIND]))
		else $error("power-down output kind not written");
	shift_write_a: assert property (
		wr_en_i && wr_addr_i == OFS_TIMING_SHIFT |=>
			cfg_o.advance == $past(wr_data_i[POS_ADVANCE]) &&
			cfg_o.delay == $past(wr_data_i[POS_DELAY]))
		else $error("advance or delay not written");
	width_write_a: assert property (
		wr_en_i && wr_addr_i == OFS_TIMING_SHIFT |=>
			cfg_o.pend.word_width == $past(wr_data_i[POS_WORD_WIDTH +: 3]))
		else $error("word width not written");
	mode_write_a: assert property (
		wr_en_i && wr_addr_i == OFS_MODE_DIVIDER |=>
			cfg_o.pend.interleave == $past(wr_data_i[POS_INTERLEAVE +: 3]) &&
			cfg_o.pend.precision == $past(wr_data_i[POS_PRECISION]) &&
			cfg_o.pend.divide == $past(wr_data_i[POS_DIVIDE +: 2]))
		else $error("mode and divider fields not written");
	route_immediate_a: assert property (
		route_write |=>
			cfg_o.route3 == $past(wr_data_i[POS_ROUTE3 +: 5]) &&
			cfg_o.route4 == $past(wr_data_i[POS_ROUTE4 +: 5]))
		else $error("routing not applied at command end");
	held_until_pd_a: assert property (
		!st.pd_sync && !soft_reset |=> $stable(active_o))
		else $error("held field changed outside power-down");
	pd_applies_a: assert property (
		pd_window |=> active_o == $past(cfg_o.pend, 2) || $past(wr_en_i, 2))
		else $error("power-down did not apply held fields");
	precision_decode_a: assert property (
		active_o.precision && active_o.interleave == '0 |-> mode_o == MODE_PRECISION)
		else $error("precision mode not decoded");
	branch_count_a: assert property (
		mode_o == MODE_PRECISION |-> branches_o == BR_PREC && conv_channel_o == MAP_QUAD)
		else $error("precision mode branch count wrong");
	single_branches_a: assert property (
		mode_o == MODE_SINGLE |-> branches_o == BR_SINGLE && conv_channel_o == MAP_SINGLE)
		else $error("single channel branch count wrong");
	dual_pairs_a: assert property (
		mode_o == MODE_DUAL |-> branches_o == BR_DUAL && conv_channel_o == MAP_DUAL)
		else $error("dual channel pairing wrong");
	quad_map_a: assert property (
		mode_o == MODE_QUAD |-> branches_o == BR_QUAD && conv_channel_o == MAP_QUAD)
		else $error("quad channel mapping wrong");
	divide_one_a: assert property (
		active_o.divide == 2'h0 |-> sample_en_o)
		else $error("divide by one missed a tick");
	divide_two_a: assert property (
		half_tick ##0 quiet_two |-> !sample_en_o ##1 sample_en_o)
		else $error("divide by two enable spacing wrong");
	trim_write_a: assert property (
		wr_en_i && wr_addr_i == OFS_FS_TRIM |=>
			cfg_o.trim == $past(wr_data_i[POS_TRIM +: 6]))
		else $error("full-scale trim not written");

endmodule : adc_mode_and_output_config

// *** verif/host_model.sv ***
/*
 * host_model: host controller on the serial control side of the bank;
 * issues one write strobe per completed command and steers the read offset.
 * Assumes a rising-edge bank clock; requests change only at falling edges.
 */
`timescale 1ns/1ps
module host_model
	import adc_cfg_pkg::*;
(
	input  wire logic              clock_i,   // bank clock
	output logic                   wr_en_o,   // write strobe
	output logic      [ADDR_W-1:0] wr_addr_o, // write offset
	output logic      [DATA_W-1:0] wr_data_o, // write data
	output logic      [ADDR_W-1:0] rd_addr_o, // read offset
	input  wire logic [DATA_W-1:0] rd_data_i  // read data
);
	initial begin
		wr_en_o = 1'b0;
		wr_addr_o = 8'hff;
		wr_data_o = 16'hffff;
		rd_addr_o = 8'h00;
	end

	// callers pass only defined offsets with unused bits already zero
	task automatic wr(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data);
		@(negedge clock_i);
		wr_en_o <= 1'b1;
		wr_addr_o <= addr;
		wr_data_o <= data;
		@(negedge clock_i);
		wr_en_o <= 1'b0;
		// released lines show the inverse so stale values cannot pass
		wr_addr_o <= ~addr;
		wr_data_o <= ~data;
	endtask : wr

	task automatic rd(input logic [ADDR_W-1:0] addr, output logic [DATA_W-1:0] data);
		@(negedge clock_i);
		rd_addr_o <= addr;
		@(negedge clock_i);
		data = rd_data_i;
	endtask : rd
endmodule : host_model

// *** verif/adc_mode_and_output_config_tb_top.sv ***
/*
 * adc_mode_and_output_config_tb_top: self-checking bench for the config bank.
 * Assumes the host model above and a two-flop synchronised power-down pin.
 */
`timescale 1ns/1ps
module adc_mode_and_output_config_tb_top;
	import adc_cfg_pkg::*;
	logic              clock_i = 1'b0;
	logic              reset_i = 1'b1;
	logic              powerdown_i = 1'b0;
	logic              wr_en;
	logic [ADDR_W-1:0] wr_addr;
	logic [DATA_W-1:0] wr_data;
	logic [ADDR_W-1:0] rd_addr;
	logic [DATA_W-1:0] rd_data;
	cfg_t              cfg;
	pd_cfg_t           active;
	mode_t             mode;
	logic [3:0]        branches;
	logic [7:0]        conv_map;
	logic              sample_en;
	int                err_total = 0;
	int                checks_done = 0;
	logic [15:0]       model [0:255];
	logic [15:0]       got;
	logic [7:0]        ofs [0:10] = '{8'h00, 8'h31, 8'h3b, 8'h42, 8'h45, 8'h46, 8'h50,
		8'h52, 8'h53, 8'h55, 8'h56};
	int                cnt;
	int                seed_val;

	always #25 clock_i = ~clock_i;

	host_model u_host (.clock_i(clock_i), .wr_en_o(wr_en), .wr_addr_o(wr_addr),
		.wr_data_o(wr_data), .rd_addr_o(rd_addr), .rd_data_i(rd_data));

	adc_mode_and_output_config DUT (.clock_i(clock_i), .reset_i(reset_i), .wr_en_i(wr_en),
		.wr_addr_i(wr_addr), .wr_data_i(wr_data), .rd_addr_i(rd_addr), .rd_data_o(rd_data),
		.powerdown_i(powerdown_i), .cfg_o(cfg), .active_o(active), .mode_o(mode),
		.branches_o(branches), .conv_channel_o(conv_map), .sample_en_o(sample_en));

	function automatic logic [15:0] field_mask(input logic [7:0] a);
		case (a)
			8'h31: return 16'h030f;
			8'h3b: return 16'h1f1f;
			8'h42: return 16'h0060;
			8'h45: return 16'h0003;
			8'h46: return 16'h000c;
			8'h50: return 16'h0037;
			8'h53: return 16'h003f;
			8'h52: return 16'h0001;
			8'h55: return 16'h003f;
			8'h56: return 16'h0007;
			default: return 16'h0000;
		endcase
	endfunction : field_mask

	task automatic model_reset();
		foreach (model[i]) model[i] = 16'h0000;
		model[8'h31] = 16'h0004;
		model[8'h3b] = 16'h1008;
		model[8'h42] = 16'h0040;
		model[8'h55] = 16'h0020;
	endtask : model_reset

	task automatic check(input logic [15:0] g, input logic [15:0] e, input string what);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, g, e);
		end
	endtask : check

	task automatic check_all_regs();
		for (int i = 0; i < 11; i++) begin
			u_host.rd(ofs[i], got);
			check(got, model[ofs[i]], "register readback");
		end
	endtask : check_all_regs

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : report_and_stop

	initial begin
		#(50 * 20000);
		err_total++;
		report_and_stop();
	end

	initial begin
		logic [15:0] d;
		logic [2:0] il;
		seed_val = $urandom(32'h7fc6);
		model_reset();
		repeat (6) @(negedge clock_i);
		reset_i <= 1'b0;
		check_all_regs();
		u_host.rd(8'h01, got);
		check(got, 16'h0000, "unmapped offset");
		check({14'h0, active.divide}, 16'h0000, "reset divider");
		// random fields except the mode register kept at 16'h0004, unused bits zero, writes one idle cycle apart
		for (int r = 0; r < 4; r++) begin
			for (int i = 1; i < 11; i++) begin
				d = $urandom() & field_mask(ofs[i]);
				if (ofs[i] == 8'h31) d = 16'h0004;
				u_host.wr(ofs[i], d);
				model[ofs[i]] = d;
				if (ofs[i] == 8'h3b) begin
					check({3'h0, cfg.route4, 3'h0, cfg.route3}, d, "routing at command end");
				end
			end
			check_all_regs();
			check({14'h0, cfg.advance, cfg.delay}, {14'h0, model[8'h53][4], model[8'h53][5]},
				"lane shift");
			check({10'h0, cfg.trim}, model[8'h55], "trim field");
			check({13'h0, cfg.twos, cfg.msb_first, cfg.sync_pat}, {13'h0, model[8'h46][2],
				model[8'h46][3], model[8'h45][1]}, "format order sync");
			check({7'h0, cfg.phase, cfg.deskew, cfg.pd_kind, cfg.current, cfg.vcm},
				{7'h0, model[8'h42][6:5], model[8'h45][0], model[8'h52][0],
				model[8'h50][2:0], model[8'h50][5:4]}, "phase pattern drive");
		end
		// each mode with its own divider code, 0..3 in turn, through a power-down cycle
		for (int m = 0; m < 4; m++) begin
			il = (m == 0) ? 3'h1 : (m == 1) ? 3'h2 : (m == 2) ? 3'h4 : 3'h0;
			d = {6'h0, m[1:0], 4'h0, (m == 3), il};
			u_host.wr(8'h31, d);
			model[8'h31] = d;
			repeat (4) @(negedge clock_i);
			check({14'h0, active.divide}, 16'(m == 0 ? 0 : m - 1), "held until power-down");
			powerdown_i <= 1'b1;
			u_host.wr(8'h42, 16'h0020);
			model[8'h42] = 16'h0020;
			u_host.rd(8'h42, got);
			check(got, 16'h0020, "write in power-down");
			repeat (4) @(negedge clock_i);
			check({13'h0, mode}, 16'(m == 0 ? MODE_SINGLE : m == 1 ? MODE_DUAL :
				m == 2 ? MODE_QUAD : MODE_PRECISION), "mode decode");
			check({3'h0, active}, {3'h0, model[8'h53][2:0], model[8'h53][3],
				model[8'h56][2:0], model[8'h31][3], model[8'h31][2:0],
				model[8'h31][9:8]}, "held fields applied");
			check({12'h0, branches}, 16'(8 >> m == 0 ? 1 : 8 >> m), "branches");
			check({8'h0, conv_map}, m == 0 ? 16'h0000 : m == 1 ? 16'h0050 : 16'h00e4,
				"converter map");
			cnt = 0;
			repeat (16) begin
				@(negedge clock_i);
				cnt += int'(sample_en === 1'b1);
			end
			check(16'(cnt), 16'(16 >> m), "sample rate");
			powerdown_i <= 1'b0;
		end
		// soft reset restores everything, power-down fields included
		u_host.wr(8'h00, 16'h0001);
		model_reset();
		check_all_regs();
		check({8'h0, conv_map}, 16'h00e4, "map after soft reset");
		check({13'h0, mode}, 16'(MODE_QUAD), "mode after soft reset");
		report_and_stop();
	end
endmodule : adc_mode_and_output_config_tb_top
